// ### inc/dcm_pkg.sv
// Constants for the DMA command and channel mode configuration block
package dcm_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned MODE_W = 6;
  localparam int unsigned CHAN_PER_GRP = 4;
  localparam int unsigned SEL_W = 2;
  // I/O addresses
  localparam logic [15:0] LOW_CMD_ADDR = 16'h0008;
  localparam logic [15:0] LOW_MODE_ADDR = 16'h000B;
  localparam logic [15:0] HIGH_CMD_ADDR = 16'h00D0;
  localparam logic [15:0] HIGH_MODE_ADDR = 16'h00D6;
  // Command register fields
  localparam int unsigned CMD_ACK_HIGH_BIT = 7;
  localparam int unsigned CMD_REQ_LOW_BIT = 6;
  localparam int unsigned CMD_ROTATE_BIT = 4;
  localparam int unsigned CMD_DISABLE_BIT = 2;
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [7:0] CMD_WRITABLE = 8'hD4;
  // Mode register fields
  localparam int unsigned MODE_XMODE_HI = 7;
  localparam int unsigned MODE_XMODE_LO = 6;
  localparam int unsigned MODE_DEC_BIT = 5;
  localparam int unsigned MODE_AUTO_BIT = 4;
  localparam int unsigned MODE_TYPE_HI = 3;
  localparam int unsigned MODE_TYPE_LO = 2;
  localparam int unsigned MODE_SEL_HI = 1;
  localparam int unsigned MODE_SEL_LO = 0;
  localparam logic [5:0] MODE_RESET = 6'h00;
  localparam logic [1:0] XMODE_DEMAND = 2'h0;
  localparam logic [1:0] XMODE_SINGLE = 2'h1;
  localparam logic [1:0] XMODE_BLOCK = 2'h2;
  localparam logic [1:0] XMODE_CASCADE = 2'h3;
  localparam logic [1:0] XTYPE_VERIFY = 2'h0;
  localparam logic [1:0] XTYPE_WRITE = 2'h1;
  localparam logic [1:0] XTYPE_READ = 2'h2;
  localparam logic [1:0] XTYPE_ILLEGAL = 2'h3;
endpackage

// ### rtl/dcm_group_cmd.sv
// Command register of one DMA controller group
`timescale 1ns/100ps
`default_nettype none
module dcm_group_cmd (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic clear,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] cmd_q
);
  // Reserved bits are dropped so a careless write cannot leak into them
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cmd_q <= dcm_pkg::CMD_RESET; // R14
    end else if (clear) begin
      cmd_q <= dcm_pkg::CMD_RESET; // R14
    end else if (wr_en) begin
      cmd_q <= wr_data & dcm_pkg::CMD_WRITABLE; // R6
    end
  end
endmodule
`default_nettype wire

// ### rtl/dcm_mode_bank.sv
// Per-channel stored mode settings of one DMA controller group
`timescale 1ns/100ps
`default_nettype none
module dcm_mode_bank #(
  parameter int unsigned CHANS = 4
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic clear,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [CHANS*6-1:0] mode_q
);
  logic [1:0] sel;
  logic [5:0] payload;
  assign sel = wr_data[dcm_pkg::MODE_SEL_HI:dcm_pkg::MODE_SEL_LO]; // R12
  assign payload = wr_data[dcm_pkg::MODE_XMODE_HI:dcm_pkg::MODE_TYPE_LO];
  genvar g;
  generate
    for (g = 0; g < CHANS; g++) begin : g_chan
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          mode_q[g*6 +: 6] <= dcm_pkg::MODE_RESET; // R14
        end else if (clear) begin
          mode_q[g*6 +: 6] <= dcm_pkg::MODE_RESET; // R14
        end else if (wr_en && (sel == 2'(g))) begin
          mode_q[g*6 +: 6] <= payload; // R13 R18
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ### rtl/dcm_config.sv
// DMA command and channel mode configuration for the cascaded controller pair
//
// Behaviour
// R1: Command bit 7 set makes acknowledges active high, clear active low.
// R2: Command bit 6 set senses requests active low, clear active high.
// R3: Command bit 4 picks rotating priority when set, fixed when clear.
// R4: Command bit 2 set disables all channels of that controller.
// R5: Disabling the upper group also stops all lower group channels.
// R6: Software writes zero to reserved command bits 5, 3, 1:0.
// R7: Mode bits 7:6 give demand, single, block or cascade transfer mode.
// R8: Mode bit 5 clear increments address, set decrements it.
// R9: Mode bit 4 set enables autoinitialization for the channel.
// R10: Mode bits 3:2 give verify, write, read; code 11 illegal.
// R11: In cascade mode the transfer type field is ignored.
// R12: Mode bits 1:0 select which of four channels gets bits 7:2.
// R13: Each channel keeps its own 6-bit stored mode.
// R14: CPU reset or master clear zeroes command and stored mode bits.
// R15: Command register decoded at 08h lower and 0D0h upper.
// R16: Mode register decoded at 0Bh lower and 0D6h upper.
// R17: All registers reachable from PCI I/O; some from ISA I/O.
// R18: Mode write changes only the selected channel.
`timescale 1ns/100ps
`default_nettype none
module dcm_config #(
  parameter int unsigned CHANS = 8,
  parameter bit ISA_CMD_VISIBLE = 1'b1,
  parameter bit ISA_MODE_VISIBLE = 1'b1
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic cpu_reset_input,
  input wire logic master_clear_low,
  input wire logic master_clear_high,
  input wire logic pci_io_wr,
  input wire logic isa_io_wr,
  input wire logic [15:0] io_addr,
  input wire logic [7:0] io_wdata,
  output logic [1:0] ack_active_high,
  output logic [1:0] req_active_low,
  output logic [1:0] rotating_priority,
  output logic [CHANS-1:0] channel_enable,
  output logic [CHANS*2-1:0] chan_xfer_mode,
  output logic [CHANS-1:0] chan_addr_decrement,
  output logic [CHANS-1:0] chan_autoinit,
  output logic [CHANS*2-1:0] chan_xfer_type,
  output logic [CHANS-1:0] chan_type_illegal,
  output logic [3:0] write_hit
);
  localparam int unsigned HALF = CHANS / 2;
  // Stored mode is register bits 7:2 shifted down, so field positions move with the payload
  localparam int unsigned ST_XMODE_HI = dcm_pkg::MODE_XMODE_HI - dcm_pkg::MODE_TYPE_LO;
  localparam int unsigned ST_XMODE_LO = dcm_pkg::MODE_XMODE_LO - dcm_pkg::MODE_TYPE_LO;
  localparam int unsigned ST_DEC_BIT = dcm_pkg::MODE_DEC_BIT - dcm_pkg::MODE_TYPE_LO;
  localparam int unsigned ST_AUTO_BIT = dcm_pkg::MODE_AUTO_BIT - dcm_pkg::MODE_TYPE_LO;
  localparam int unsigned ST_TYPE_HI = dcm_pkg::MODE_TYPE_HI - dcm_pkg::MODE_TYPE_LO;
  localparam int unsigned ST_TYPE_W = dcm_pkg::MODE_TYPE_HI - dcm_pkg::MODE_TYPE_LO + 1;
  localparam int unsigned STORED_W = dcm_pkg::MODE_W;

  // CPU reset pin is asynchronous to clock, so it crosses three stages
  logic sync1_reg;
  logic sync2_reg;
  logic sync3_reg;
  logic cpu_reset_reg;
  logic cpu_reset_seen;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sync1_reg <= 1'b0;
    end else begin
      sync1_reg <= cpu_reset_input;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sync2_reg <= 1'b0;
    end else begin
      sync2_reg <= sync1_reg;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sync3_reg <= 1'b0;
    end else begin
      sync3_reg <= sync2_reg;
    end
  end

  // Only stage two reads stage one; a change counts once stages two and three agree
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cpu_reset_reg <= 1'b0;
    end else if (sync2_reg == sync3_reg) begin
      cpu_reset_reg <= sync3_reg;
    end
  end
  assign cpu_reset_seen = cpu_reset_reg;

  // Address decode; ISA side reaches only what the parameters allow
  logic wr_any;
  logic cmd_isa_ok;
  logic mode_isa_ok;
  logic wr_low_cmd;
  logic wr_high_cmd;
  logic wr_low_mode;
  logic wr_high_mode;
  assign wr_any = pci_io_wr | isa_io_wr;
  assign cmd_isa_ok = pci_io_wr | (isa_io_wr & ISA_CMD_VISIBLE); // R17
  assign mode_isa_ok = pci_io_wr | (isa_io_wr & ISA_MODE_VISIBLE); // R17
  logic at_low_cmd;
  logic at_high_cmd;
  logic at_low_mode;
  logic at_high_mode;
  assign at_low_cmd = (io_addr == dcm_pkg::LOW_CMD_ADDR); // R15
  assign at_high_cmd = (io_addr == dcm_pkg::HIGH_CMD_ADDR); // R15
  assign at_low_mode = (io_addr == dcm_pkg::LOW_MODE_ADDR); // R16
  assign at_high_mode = (io_addr == dcm_pkg::HIGH_MODE_ADDR); // R16
  assign wr_low_cmd = cmd_isa_ok && at_low_cmd; // R15
  assign wr_high_cmd = cmd_isa_ok && at_high_cmd; // R15
  assign wr_low_mode = mode_isa_ok && at_low_mode; // R16
  assign wr_high_mode = mode_isa_ok && at_high_mode; // R16

  logic clr_low;
  logic clr_high;
  assign clr_low = cpu_reset_seen | master_clear_low; // R14
  assign clr_high = cpu_reset_seen | master_clear_high; // R14

  logic [7:0] cmd_low;
  logic [7:0] cmd_high;
  logic [HALF*6-1:0] mode_low;
  logic [HALF*6-1:0] mode_high;

  dcm_group_cmd u_cmd_low (
    .clock(clock),
    .arst_n(arst_n),
    .clear(clr_low),
    .wr_en(wr_low_cmd),
    .wr_data(io_wdata),
    .cmd_q(cmd_low)
  );
  dcm_group_cmd u_cmd_high (
    .clock(clock),
    .arst_n(arst_n),
    .clear(clr_high),
    .wr_en(wr_high_cmd),
    .wr_data(io_wdata),
    .cmd_q(cmd_high)
  );
  dcm_mode_bank #(.CHANS(HALF)) u_mode_low (
    .clock(clock),
    .arst_n(arst_n),
    .clear(clr_low),
    .wr_en(wr_low_mode),
    .wr_data(io_wdata),
    .mode_q(mode_low)
  );
  dcm_mode_bank #(.CHANS(HALF)) u_mode_high (
    .clock(clock),
    .arst_n(arst_n),
    .clear(clr_high),
    .wr_en(wr_high_mode),
    .wr_data(io_wdata),
    .mode_q(mode_high)
  );

  // Group command fields, bit 0 lower and bit 1 upper
  logic [1:0] grp_ack_high;
  logic [1:0] grp_req_low;
  logic [1:0] grp_rotate;
  assign grp_ack_high = {cmd_high[dcm_pkg::CMD_ACK_HIGH_BIT], cmd_low[dcm_pkg::CMD_ACK_HIGH_BIT]}; // R1
  assign grp_req_low = {cmd_high[dcm_pkg::CMD_REQ_LOW_BIT], cmd_low[dcm_pkg::CMD_REQ_LOW_BIT]}; // R2
  assign grp_rotate = {cmd_high[dcm_pkg::CMD_ROTATE_BIT], cmd_low[dcm_pkg::CMD_ROTATE_BIT]}; // R3

  // Group controls, registered so every output leaves a flip-flop
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ack_active_high <= 2'h0;
    end else begin
      ack_active_high <= grp_ack_high; // R1
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      req_active_low <= 2'h0;
    end else begin
      req_active_low <= grp_req_low; // R2
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rotating_priority <= 2'h0;
    end else begin
      rotating_priority <= grp_rotate; // R3
    end
  end

  // Lower group is cascaded through upper channel four, so upper disable stops it too
  logic low_group_disable;
  logic high_group_disable;
  logic low_off;
  logic high_off;
  assign low_group_disable = cmd_low[dcm_pkg::CMD_DISABLE_BIT]; // R4
  assign high_group_disable = cmd_high[dcm_pkg::CMD_DISABLE_BIT]; // R4
  assign high_off = high_group_disable; // R4
  assign low_off = low_group_disable | high_group_disable; // R5

  // One pulse per decoded write, so the host side can tell where a write landed
  logic [3:0] hit_now;
  assign hit_now = {wr_high_mode, wr_low_mode, wr_high_cmd, wr_low_cmd} & {4{wr_any}};
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      write_hit <= 4'h0;
    end else begin
      write_hit <= hit_now;
    end
  end

  genvar c;
  generate
    for (c = 0; c < CHANS; c++) begin : g_out
      logic [STORED_W-1:0] m;
      logic off;
      logic [1:0] m_xmode;
      logic m_dec;
      logic m_auto;
      logic [1:0] m_xtype;
      logic m_cascade;

      if (c < HALF) begin : g_lo
        assign m = mode_low[c*STORED_W +: STORED_W];
        assign off = low_off;
      end else begin : g_hi
        assign m = mode_high[(c-HALF)*STORED_W +: STORED_W];
        assign off = high_off;
      end

      assign m_xmode = m[ST_XMODE_HI:ST_XMODE_LO]; // R7
      assign m_dec = m[ST_DEC_BIT]; // R8
      assign m_auto = m[ST_AUTO_BIT]; // R9
      assign m_xtype = m[ST_TYPE_HI -: ST_TYPE_W]; // R10
      assign m_cascade = (m_xmode == dcm_pkg::XMODE_CASCADE); // R11

      // Upper disable reaches the lower channels through low_off
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          channel_enable[c] <= 1'b1;
        end else begin
          channel_enable[c] <= ~off; // R4 R5
        end
      end

      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          chan_xfer_mode[c*2 +: 2] <= dcm_pkg::XMODE_DEMAND;
        end else begin
          chan_xfer_mode[c*2 +: 2] <= m_xmode; // R7
        end
      end

      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          chan_addr_decrement[c] <= 1'b0;
        end else begin
          chan_addr_decrement[c] <= m_dec; // R8
        end
      end

      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          chan_autoinit[c] <= 1'b0;
        end else begin
          chan_autoinit[c] <= m_auto; // R9
        end
      end

      // Cascade makes the type irrelevant, so it reads as verify and never as illegal
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          chan_xfer_type[c*2 +: 2] <= dcm_pkg::XTYPE_VERIFY;
        end else if (m_cascade) begin
          chan_xfer_type[c*2 +: 2] <= dcm_pkg::XTYPE_VERIFY; // R11
        end else begin
          chan_xfer_type[c*2 +: 2] <= m_xtype; // R10
        end
      end

      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          chan_type_illegal[c] <= 1'b0;
        end else if (m_cascade) begin
          chan_type_illegal[c] <= 1'b0; // R11
        end else begin
          chan_type_illegal[c] <= (m_xtype == dcm_pkg::XTYPE_ILLEGAL); // R10
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ### dv/dcm_config_monitor.sv
// Checker for the DMA command and channel mode configuration block
`timescale 1ns/100ps
`default_nettype none
module dcm_config_monitor #(
  parameter int unsigned CHANS = 8
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic cpu_reset_input,
  input wire logic master_clear_low,
  input wire logic master_clear_high,
  input wire logic pci_io_wr,
  input wire logic isa_io_wr,
  input wire logic [15:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic [1:0] ack_active_high,
  input wire logic [1:0] req_active_low,
  input wire logic [1:0] rotating_priority,
  input wire logic [CHANS-1:0] channel_enable,
  input wire logic [CHANS*2-1:0] chan_xfer_mode,
  input wire logic [CHANS-1:0] chan_addr_decrement,
  input wire logic [CHANS-1:0] chan_autoinit,
  input wire logic [CHANS*2-1:0] chan_xfer_type,
  input wire logic [CHANS-1:0] chan_type_illegal,
  input wire logic [3:0] write_hit
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  property p_lcmd; (pci_io_wr || isa_io_wr) && io_addr == dcm_pkg::LOW_CMD_ADDR |=> write_hit[0]; endproperty
  a_lcmd: assert property (p_lcmd) else $error("low command write missed");
  property p_hmode; (pci_io_wr || isa_io_wr) && io_addr == dcm_pkg::HIGH_MODE_ADDR |=> write_hit[3]; endproperty
  a_hmode: assert property (p_hmode) else $error("high mode write missed");
  property p_ack; write_hit[0] |=> ack_active_high[0] == $past(io_wdata[7], 2); endproperty
  a_ack: assert property (p_ack) else $error("ack polarity wrong");
  property p_req; write_hit[1] |=> req_active_low[1] == $past(io_wdata[6], 2); endproperty
  a_req: assert property (p_req) else $error("request sense wrong");
  property p_rot; write_hit[0] |=> rotating_priority[0] == $past(io_wdata[4], 2); endproperty
  a_rot: assert property (p_rot) else $error("priority scheme wrong");
  property p_dis; write_hit[1] |=> channel_enable[7] != $past(io_wdata[2], 2); endproperty
  a_dis: assert property (p_dis) else $error("group disable wrong");
  property p_chain; !channel_enable[4] |-> channel_enable[3:0] == 4'h0; endproperty
  a_chain: assert property (p_chain) else $error("lower group still enabled");
  // Cascade hides the type, so the flag must follow the visible code only outside cascade
  property p_ill; chan_type_illegal[0] == (chan_xfer_type[1:0] == 2'h3 && chan_xfer_mode[1:0] != 2'h3); endproperty
  a_ill: assert property (p_ill) else $error("illegal type flag wrong");
  c_hmode: cover property (write_hit[3]);
  c_cas: cover property (chan_xfer_mode[1:0] == 2'h3);
  c_dis: cover property (!channel_enable[0]);
endmodule
bind dcm_config dcm_config_monitor #(.CHANS(CHANS)) mon_u (.clock, .arst_n, .cpu_reset_input, .master_clear_low,
  .master_clear_high, .pci_io_wr, .isa_io_wr, .io_addr, .io_wdata, .ack_active_high, .req_active_low,
  .rotating_priority, .channel_enable, .chan_xfer_mode, .chan_addr_decrement, .chan_autoinit, .chan_xfer_type,
  .chan_type_illegal, .write_hit);
`default_nettype wire

// ### dv/dcm_host_model.sv
// Host software model issuing I/O writes
`timescale 1ns/100ps
`default_nettype none
module dcm_host_model (
  input wire logic clock,
  output logic pci_io_wr = 1'b0,
  output logic isa_io_wr = 1'b0,
  output logic [15:0] io_addr = 16'h0000,
  output logic [7:0] io_wdata = 8'h00
);
  task automatic wr(input logic isa, input logic [15:0] addr, input logic [7:0] data);
    @(negedge clock);
    pci_io_wr = !isa;
    isa_io_wr = isa;
    io_addr = addr;
    io_wdata = (addr == dcm_pkg::LOW_CMD_ADDR || addr == dcm_pkg::HIGH_CMD_ADDR) ? (data & dcm_pkg::CMD_WRITABLE) : data;
    @(negedge clock);
    pci_io_wr = 1'b0;
    isa_io_wr = 1'b0;
    // Bus inverted after the strobe so stale values never look valid
    io_addr = ~addr;
    io_wdata = ~io_wdata;
  endtask
endmodule
`default_nettype wire

// ### dv/tb_dcm_config.sv
// Self-checking testbench for the DMA configuration block
`timescale 1ns/100ps
`default_nettype none
module tb_dcm_config;
  logic clock = 1'b0, arst_n = 1'b0, cpu_reset_input = 1'b0, master_clear_low = 1'b0, master_clear_high = 1'b0;
  wire logic pci_io_wr, isa_io_wr;
  wire logic [15:0] io_addr;
  wire logic [7:0] io_wdata;
  logic [1:0] ack_active_high, req_active_low, rotating_priority;
  logic [7:0] channel_enable, chan_addr_decrement, chan_autoinit, chan_type_illegal;
  logic [15:0] chan_xfer_mode, chan_xfer_type;
  logic [3:0] write_hit;
  logic [7:0] cmd_s [2] = '{8'h00, 8'h00};
  logic [5:0] mode_s [8] = '{default: 6'h00};
  int error_cnt = 0, comparisons = 0, seed = 86614;
  always #2 clock = ~clock;
  dcm_host_model host_u (.clock, .pci_io_wr, .isa_io_wr, .io_addr, .io_wdata);
  dcm_config dut_u (.clock, .arst_n, .cpu_reset_input, .master_clear_low, .master_clear_high, .pci_io_wr,
    .isa_io_wr, .io_addr, .io_wdata, .ack_active_high, .req_active_low, .rotating_priority, .channel_enable,
    .chan_xfer_mode, .chan_addr_decrement, .chan_autoinit, .chan_xfer_type, .chan_type_illegal, .write_hit);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [6:0] exp_mode(input logic [5:0] m);
    logic cas;
    cas = m[5:4] == 2'h3;
    return {m[5:4], m[3], m[2], cas ? 2'h0 : m[1:0], !cas && m[1:0] == 2'h3};
  endfunction
  task automatic check_all();
    logic [6:0] e;
    for (int c = 0; c < 8; c++) begin
      e = exp_mode(mode_s[c]);
      chk({chan_xfer_mode[2*c+:2], chan_addr_decrement[c], chan_autoinit[c]}, e[6:3]);
      chk({chan_xfer_type[2*c+:2], chan_type_illegal[c]}, e[2:0]);
      chk(channel_enable[c], !(cmd_s[1][2] || (c < 4 && cmd_s[0][2])));
    end
    chk({ack_active_high, req_active_low, rotating_priority}, {cmd_s[1][7], cmd_s[0][7], cmd_s[1][6], cmd_s[0][6],
      cmd_s[1][4], cmd_s[0][4]});
  endtask
  task automatic do_wr(input logic isa, input logic [15:0] a, input logic [7:0] d);
    logic [3:0] hit;
    host_u.wr(isa, a, d);
    hit = {a == dcm_pkg::HIGH_MODE_ADDR, a == dcm_pkg::LOW_MODE_ADDR, a == dcm_pkg::HIGH_CMD_ADDR,
      a == dcm_pkg::LOW_CMD_ADDR};
    if (hit[1:0] != 2'h0) cmd_s[hit[1]] = d & dcm_pkg::CMD_WRITABLE;
    if (hit[3:2] != 2'h0) mode_s[{hit[3], d[1:0]}] = d[7:2];
    chk(write_hit, hit);
    @(negedge clock);
    check_all();
  endtask
  task automatic rand_run(input int n);
    logic [31:0] r;
    logic [15:0] a [4] = '{dcm_pkg::LOW_CMD_ADDR, dcm_pkg::HIGH_CMD_ADDR, dcm_pkg::LOW_MODE_ADDR,
      dcm_pkg::HIGH_MODE_ADDR};
    for (int i = 0; i < n; i++) begin
      r = $random(seed);
      do_wr(r[8], a[r[10:9]], r[7:0]);
    end
  endtask
  task automatic close_out();
    if (error_cnt == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #20000;
    error_cnt++;
    close_out();
  end
  initial begin
    repeat (6) @(negedge clock);
    arst_n = 1'b1;
    check_all();
    do_wr(1'b0, dcm_pkg::LOW_MODE_ADDR, 8'hC2);
    do_wr(1'b1, dcm_pkg::LOW_MODE_ADDR, 8'h0F);
    do_wr(1'b0, dcm_pkg::HIGH_CMD_ADDR, 8'hFF);
    do_wr(1'b0, 16'h0009, 8'hFF);
    rand_run(80);
    // Each group's master clear in turn; the other group must keep its settings
    for (int g = 0; g < 2; g++) begin
      if (g == 0) master_clear_low = 1'b1;
      else master_clear_high = 1'b1;
      @(negedge clock);
      master_clear_low = 1'b0;
      master_clear_high = 1'b0;
      cmd_s[g] = 8'h00;
      for (int c = 0; c < 4; c++) mode_s[4*g+c] = 6'h00;
      @(negedge clock);
      check_all();
      rand_run(20);
    end
    cpu_reset_input = 1'b1;
    repeat (8) @(negedge clock);
    cmd_s = '{8'h00, 8'h00};
    mode_s = '{default: 6'h00};
    check_all();
    cpu_reset_input = 1'b0;
    repeat (6) @(negedge clock);
    rand_run(20);
    close_out();
  end
endmodule
`default_nettype wire
